// *** verilog/bbc_consts.svh ***
// Constants of the buck-boost register bank: offsets, fields, resets, timing
// Assumes inclusion by bare name from files under verilog/
`ifndef BBC_CONSTS_SVH
`define BBC_CONSTS_SVH

// ****************************************************************
// Serial slave address and register offsets
// ****************************************************************
`define BBC_SLAVE_ADDR 7'h75
`define BBC_OFS_SETUP 8'h01
`define BBC_OFS_FLAGS 8'h02
`define BBC_OFS_IDENT 8'h03
`define BBC_OFS_PRESET_A 8'h04
`define BBC_OFS_PRESET_B 8'h05
`define BBC_RD_ZERO 8'h00

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define BBC_FLAG_THERMAL 1
`define BBC_FLAG_REG_LOST 0
`define BBC_SETUP_RST 8'h00
`define BBC_ENABLE_BIT 5
`define BBC_PRESET_A_RST 7'h3c
`define BBC_PRESET_B_RST 7'h42
`define BBC_MAJOR_REV 2'h1
`define BBC_MINOR_REV 2'h0

// ****************************************************************
// Timing: one preset code step and the ramp rates
// ****************************************************************
`define BBC_MCLK_NS 40
`define BBC_STEP_UV 25000
`define BBC_SLEW0_UVUS 1000
`define BBC_SLEW1_UVUS 2500
`define BBC_SLEW2_UVUS 5000
`define BBC_SLEW3_UVUS 10000

`endif

// *** verilog/bbc_pkg.sv ***
// Types shared by the register bank and its serial link engine
// Assumes nothing beyond a SystemVerilog compiler
package bbc_pkg;

    // Setup register, laid out bit for bit as stored
    typedef struct packed {
        logic rsv7;
        logic range;
        logic enable;
        logic rsv4;
        logic forced_pulse_width_mode;
        logic ramp_pulse_width_mode;
        logic [1:0] slew;
    } bbc_setup_t;

    // Write request handed from the link domain to the bank
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } bbc_wreq_t;

    // Serial engine states
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_ADDR = 9'h002,
        ST_AACK = 9'h004,
        ST_REGA = 9'h008,
        ST_RACK = 9'h010,
        ST_WDAT = 9'h020,
        ST_WACK = 9'h040,
        ST_RDAT = 9'h080,
        ST_MACK = 9'h100
    } bbc_link_st_t;

endpackage

// *** verilog/bbc_link.sv ***
// Two-wire serial slave engine on the link sampling clock
// Assumes link_clk runs free and at least 8 times faster than scl
`timescale 1ns/100ps
`default_nettype none
`include "bbc_consts.svh"

module bbc_link
    import bbc_pkg::*;
(
    input wire logic link_clk,
    input wire logic arst_n,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [7:0] rd_data,
    output logic sda_o,
    output logic sda_oe,
    output logic wr_tgl,
    output bbc_wreq_t wreq,
    output logic rd_tgl,
    output logic [7:0] rd_addr
);

    // ****************************************************************
    // Pin synchronisers and edge detection
    // ****************************************************************
    logic [1:0] scl_sy_reg;
    logic [1:0] sda_sy_reg;
    logic scl_d_reg;
    logic sda_d_reg;
    logic rise;
    logic fall;
    logic start;
    logic stop;

    // Two flops per pin, then a delayed copy of the second
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_sy_reg <= 2'h3;
            sda_sy_reg <= 2'h3;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_sy_reg <= {scl_sy_reg[0], scl_i};
            sda_sy_reg <= {sda_sy_reg[0], sda_i};
            scl_d_reg <= scl_sy_reg[1];
            sda_d_reg <= sda_sy_reg[1];
        end
    end

    // Clock edges, and data edges while the clock is high
    assign rise = scl_sy_reg[1] & ~scl_d_reg;
    assign fall = ~scl_sy_reg[1] & scl_d_reg;
    assign start = scl_sy_reg[1] & scl_d_reg & sda_d_reg & ~sda_sy_reg[1];
    assign stop = scl_sy_reg[1] & scl_d_reg & ~sda_d_reg & sda_sy_reg[1];

    // ****************************************************************
    // Protocol engine
    // ****************************************************************
    bbc_link_st_t state_reg, state_next;
    logic [7:0] sh_reg, sh_next;
    logic [7:0] tx_reg, tx_next;
    logic [7:0] ptr_reg, ptr_next;
    logic [2:0] cnt_reg, cnt_next;
    logic got_reg, got_next;
    logic rw_reg, rw_next;
    logic nack_reg, nack_next;
    logic oe_reg, oe_next;
    logic wr_tgl_reg, wr_tgl_next;
    logic rd_tgl_reg, rd_tgl_next;
    logic [7:0] rd_addr_reg, rd_addr_next;
    bbc_wreq_t wreq_reg, wreq_next;
    logic rx_state;

    assign rx_state = (state_reg == ST_ADDR) || (state_reg == ST_REGA) || (state_reg == ST_WDAT);

    // Bytes are taken on rising scl, the bus is driven after falling scl
    always_comb begin
        state_next = state_reg;
        sh_next = sh_reg;
        tx_next = tx_reg;
        ptr_next = ptr_reg;
        cnt_next = cnt_reg;
        got_next = got_reg;
        rw_next = rw_reg;
        nack_next = nack_reg;
        oe_next = oe_reg;
        wr_tgl_next = wr_tgl_reg;
        rd_tgl_next = rd_tgl_reg;
        rd_addr_next = rd_addr_reg;
        wreq_next = wreq_reg;
        if (rise && rx_state) begin
            sh_next = {sh_reg[6:0], sda_sy_reg[1]};
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == 3'h7) begin
                got_next = 1'b1;
            end
        end
        if (rise && state_reg == ST_MACK) begin
            nack_next = sda_sy_reg[1];
            if (!sda_sy_reg[1]) begin
                rd_tgl_next = ~rd_tgl_reg;
                rd_addr_next = ptr_reg;
            end
        end
        if (fall) begin
            unique case (state_reg)
                ST_IDLE: begin
                end
                ST_ADDR: begin
                    if (got_reg) begin
                        got_next = 1'b0;
                        if (sh_reg[7:1] == `BBC_SLAVE_ADDR) begin
                            state_next = ST_AACK;
                            oe_next = 1'b1;
                            rw_next = sh_reg[0];
                            if (sh_reg[0]) begin
                                rd_tgl_next = ~rd_tgl_reg;
                                rd_addr_next = ptr_reg;
                            end
                        end else begin
                            state_next = ST_IDLE;
                        end
                    end
                end
                ST_AACK: begin
                    cnt_next = 3'h0;
                    if (rw_reg) begin
                        state_next = ST_RDAT;
                        tx_next = rd_data;
                        oe_next = ~rd_data[7];
                    end else begin
                        state_next = ST_REGA;
                        oe_next = 1'b0;
                    end
                end
                ST_REGA: begin
                    if (got_reg) begin
                        got_next = 1'b0;
                        ptr_next = sh_reg;
                        state_next = ST_RACK;
                        oe_next = 1'b1;
                    end
                end
                ST_RACK: begin
                    cnt_next = 3'h0;
                    oe_next = 1'b0;
                    state_next = ST_WDAT;
                end
                ST_WDAT: begin
                    if (got_reg) begin
                        got_next = 1'b0;
                        wreq_next = '{addr: ptr_reg, data: sh_reg};
                        state_next = ST_WACK;
                        oe_next = 1'b1;
                    end
                end
                ST_WACK: begin
                    // The update is released at the end of the acknowledge
                    cnt_next = 3'h0;
                    oe_next = 1'b0;
                    wr_tgl_next = ~wr_tgl_reg;
                    ptr_next = ptr_reg + 8'h01;
                    state_next = ST_WDAT;
                end
                ST_RDAT: begin
                    cnt_next = cnt_reg + 3'h1;
                    if (cnt_reg == 3'h7) begin
                        state_next = ST_MACK;
                        oe_next = 1'b0;
                        ptr_next = ptr_reg + 8'h01;
                    end else begin
                        tx_next = {tx_reg[6:0], 1'b0};
                        oe_next = ~tx_reg[6];
                    end
                end
                ST_MACK: begin
                    cnt_next = 3'h0;
                    if (nack_reg) begin
                        state_next = ST_IDLE;
                    end else begin
                        state_next = ST_RDAT;
                        tx_next = rd_data;
                        oe_next = ~rd_data[7];
                    end
                end
            endcase
        end
        if (start) begin
            state_next = ST_ADDR;
            cnt_next = 3'h0;
            got_next = 1'b0;
            oe_next = 1'b0;
        end else if (stop) begin
            state_next = ST_IDLE;
            oe_next = 1'b0;
        end
    end

    // Engine registers
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ST_IDLE;
            sh_reg <= 8'h00;
            tx_reg <= 8'h00;
            ptr_reg <= 8'h00;
            cnt_reg <= 3'h0;
            got_reg <= 1'b0;
            rw_reg <= 1'b0;
            nack_reg <= 1'b0;
            oe_reg <= 1'b0;
            wr_tgl_reg <= 1'b0;
            rd_tgl_reg <= 1'b0;
            rd_addr_reg <= 8'h00;
            wreq_reg <= '0;
        end else begin
            state_reg <= state_next;
            sh_reg <= sh_next;
            tx_reg <= tx_next;
            ptr_reg <= ptr_next;
            cnt_reg <= cnt_next;
            got_reg <= got_next;
            rw_reg <= rw_next;
            nack_reg <= nack_next;
            oe_reg <= oe_next;
            wr_tgl_reg <= wr_tgl_next;
            rd_tgl_reg <= rd_tgl_next;
            rd_addr_reg <= rd_addr_next;
            wreq_reg <= wreq_next;
        end
    end

    // Open drain: the data level driven is always low
    assign sda_o = 1'b0;
    assign sda_oe = oe_reg;
    assign wr_tgl = wr_tgl_reg;
    assign wreq = wreq_reg;
    assign rd_tgl = rd_tgl_reg;
    assign rd_addr = rd_addr_reg;

endmodule // bbc_link

`default_nettype wire

// *** verilog/bbc_regs.sv ***
// Register bank of a buck-boost converter behind a two-wire serial port
// Assumes mclk at 25 MHz, a free running link_clk, and asynchronous pins
`timescale 1ns/100ps
`default_nettype none
`include "bbc_consts.svh"

// What this block does
// - Decode 0x01-0x05, answer only slave 0x75
// - Setup bits 7 and 4 stored, no effect
// - Setup bit 6 picks output voltage range
// - Setup bit 5 enables converter, variant reset
// - Setup bit 3 forces pulse-width operation
// - Setup bit 2 enables ramp pulse-width operation
// - Setup bits 1:0 pick ramp rate
// - Flag register bits 7:2 read zero
// - Thermal flag sticky, cleared by read when cool
// - Regulation flag sticky, cleared by read when good
// - Identity bits 7:4 fixed maker code
// - Identity bits 3:2 major revision, read-only
// - Identity bits 1:0 minor revision, read-only
// - Preset A bit 7 reads zero always
// - Preset A code used while select low
// - Preset B code used while select high
// - Unmapped register reads return zero
// - Write lands at end of data acknowledge
// - Discharge output when pin low or disabled
module bbc_regs
    import bbc_pkg::*;
#(
    parameter logic ENABLE_AT_START = 1'b0,
    parameter logic [3:0] MAKER_ID = 4'ha, // Arbitrary value
    parameter logic [1:0] MAJOR_REV = `BBC_MAJOR_REV,
    parameter logic [1:0] MINOR_REV = `BBC_MINOR_REV
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic link_clk,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic turn_on_pin,
    input wire logic target_select_pin,
    input wire logic overtemp_i,
    input wire logic out_of_reg_i,
    output bbc_setup_t setup_o,
    output logic [6:0] vout_code_o,
    output logic [6:0] target_code_o,
    output logic converter_on_o,
    output logic discharge_o
);

    // ****************************************************************
    // Serial link engine in the link clock domain
    // ****************************************************************
    logic wr_tgl;
    logic rd_tgl;
    logic [7:0] rd_addr;
    bbc_wreq_t wreq;
    logic [7:0] rd_data_reg, rd_data_next;

    bbc_link u_link (
        .link_clk(link_clk),
        .arst_n(arst_n),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .rd_data(rd_data_reg),
        .sda_o(sda_o),
        .sda_oe(sda_oe),
        .wr_tgl(wr_tgl),
        .wreq(wreq),
        .rd_tgl(rd_tgl),
        .rd_addr(rd_addr)
    );

    // ****************************************************************
    // Crossings into mclk
    // ****************************************************************
    logic [1:0] wr_sy_reg;
    logic [1:0] rd_sy_reg;
    logic wr_seen_reg;
    logic rd_seen_reg;
    logic [1:0] on_sy_reg;
    logic [1:0] sel_sy_reg;
    logic [1:0] ot_sy_reg;
    logic [1:0] ol_sy_reg;
    logic wr_fire;
    logic rd_fire;
    logic on_s;
    logic sel_s;
    logic ot_s;
    logic ol_s;

    // Toggles and pin levels each pass two flops
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wr_sy_reg <= 2'h0;
            rd_sy_reg <= 2'h0;
            wr_seen_reg <= 1'b0;
            rd_seen_reg <= 1'b0;
            on_sy_reg <= 2'h0;
            sel_sy_reg <= 2'h0;
            ot_sy_reg <= 2'h0;
            ol_sy_reg <= 2'h0;
        end else begin
            wr_sy_reg <= {wr_sy_reg[0], wr_tgl};
            rd_sy_reg <= {rd_sy_reg[0], rd_tgl};
            wr_seen_reg <= wr_sy_reg[1];
            rd_seen_reg <= rd_sy_reg[1];
            on_sy_reg <= {on_sy_reg[0], turn_on_pin};
            sel_sy_reg <= {sel_sy_reg[0], target_select_pin};
            ot_sy_reg <= {ot_sy_reg[0], overtemp_i};
            ol_sy_reg <= {ol_sy_reg[0], out_of_reg_i};
        end
    end

    // Request pulses; write address and data settle before their toggle, the read address with its toggle
    assign wr_fire = wr_sy_reg[1] ^ wr_seen_reg;
    assign rd_fire = rd_sy_reg[1] ^ rd_seen_reg;
    assign on_s = on_sy_reg[1];
    assign sel_s = sel_sy_reg[1];
    assign ot_s = ot_sy_reg[1];
    assign ol_s = ol_sy_reg[1];

    // ****************************************************************
    // Register bank
    // ****************************************************************
    bbc_setup_t setup_reg, setup_next;
    logic [6:0] pa_reg, pa_next;
    logic [6:0] pb_reg, pb_next;
    logic [1:0] flags_reg, flags_next;
    logic flag_rd;

    assign flag_rd = rd_fire && (rd_addr == `BBC_OFS_FLAGS);

    // Writes, read capture, and the sticky flags
    always_comb begin
        setup_next = setup_reg;
        pa_next = pa_reg;
        pb_next = pb_reg;
        rd_data_next = rd_data_reg;
        if (wr_fire) begin
            case (wreq.addr)
                `BBC_OFS_SETUP: setup_next = wreq.data;
                `BBC_OFS_PRESET_A: pa_next = wreq.data[6:0];
                `BBC_OFS_PRESET_B: pb_next = wreq.data[6:0];
                default: begin
                end
            endcase
        end
        if (rd_fire) begin
            case (rd_addr)
                `BBC_OFS_SETUP: rd_data_next = setup_reg;
                `BBC_OFS_FLAGS: rd_data_next = {6'h00, flags_reg};
                `BBC_OFS_IDENT: rd_data_next = {MAKER_ID, MAJOR_REV, MINOR_REV};
                `BBC_OFS_PRESET_A: rd_data_next = {1'b0, pa_reg};
                `BBC_OFS_PRESET_B: rd_data_next = {1'b0, pb_reg};
                default: rd_data_next = `BBC_RD_ZERO;
            endcase
        end
        // A present condition always wins over the clearing read
        flags_next[`BBC_FLAG_THERMAL] = ot_s
            | (flags_reg[`BBC_FLAG_THERMAL] & ~flag_rd);
        flags_next[`BBC_FLAG_REG_LOST] = ol_s
            | (flags_reg[`BBC_FLAG_REG_LOST] & ~flag_rd);
    end

    // Bank registers; the enable bit resets per product variant
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            setup_reg <= `BBC_SETUP_RST | (8'(ENABLE_AT_START) << `BBC_ENABLE_BIT);
            pa_reg <= `BBC_PRESET_A_RST;
            pb_reg <= `BBC_PRESET_B_RST;
            flags_reg <= 2'h0;
            rd_data_reg <= 8'h00;
        end else begin
            setup_reg <= setup_next;
            pa_reg <= pa_next;
            pb_reg <= pb_next;
            flags_reg <= flags_next;
            rd_data_reg <= rd_data_next;
        end
    end

    // ****************************************************************
    // Target select, ramp and converter control
    // ****************************************************************
    logic [6:0] target_reg, target_next;
    logic [6:0] ramp_reg, ramp_next;
    logic [9:0] cnt_reg, cnt_next;
    logic on_reg, on_next;
    logic dis_reg, dis_next;

    // Cycles per 25 mV code step at each ramp rate
    function automatic logic [9:0] step_len(input logic [1:0] slew);
        logic [9:0] n;
        n = 10'h001;
        case (slew)
            2'h0: n = 10'(`BBC_STEP_UV * 1000 / `BBC_SLEW0_UVUS / `BBC_MCLK_NS);
            2'h1: n = 10'(`BBC_STEP_UV * 1000 / `BBC_SLEW1_UVUS / `BBC_MCLK_NS);
            2'h2: n = 10'(`BBC_STEP_UV * 1000 / `BBC_SLEW2_UVUS / `BBC_MCLK_NS);
            default: n = 10'(`BBC_STEP_UV * 1000 / `BBC_SLEW3_UVUS / `BBC_MCLK_NS);
        endcase
        return n;
    endfunction

    // Step the output code one code at a time toward the target
    always_comb begin
        target_next = sel_s ? pb_reg : pa_reg;
        ramp_next = ramp_reg;
        cnt_next = 10'h000;
        if (ramp_reg != target_reg) begin
            if (cnt_reg >= step_len(setup_reg.slew) - 10'h001) begin
                ramp_next = (ramp_reg < target_reg) ? ramp_reg + 7'h01
                                                    : ramp_reg - 7'h01;
            end else begin
                cnt_next = cnt_reg + 10'h001;
            end
        end
        on_next = on_s & setup_reg.enable;
        dis_next = ~(on_s & setup_reg.enable);
    end

    // Ramp and control registers
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            target_reg <= `BBC_PRESET_A_RST;
            ramp_reg <= `BBC_PRESET_A_RST;
            cnt_reg <= 10'h000;
            on_reg <= 1'b0;
            dis_reg <= 1'b1;
        end else begin
            target_reg <= target_next;
            ramp_reg <= ramp_next;
            cnt_reg <= cnt_next;
            on_reg <= on_next;
            dis_reg <= dis_next;
        end
    end

    assign setup_o = setup_reg;
    assign vout_code_o = ramp_reg;
    assign target_code_o = target_reg;
    assign converter_on_o = on_reg;
    assign discharge_o = dis_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    a_setup_write: assert property (
        wr_fire && wreq.addr == `BBC_OFS_SETUP |=> setup_o == $past(wreq.data))
        else $error("setup write not stored");
    a_mode_cause: assert property (
        $changed(setup_o) |-> $past(wr_fire && wreq.addr == `BBC_OFS_SETUP))
        else $error("setup changed without a write");
    a_flag_pad: assert property (
        flag_rd |=> rd_data_reg == {6'h00, $past(flags_reg)})
        else $error("flag read wrong");
    a_thermal_set: assert property (
        ot_s ##1 !flag_rd |-> flags_reg[`BBC_FLAG_THERMAL] [*2])
        else $error("thermal flag not held while hot");
    a_lost_clear: assert property (
        $fell(flags_reg[`BBC_FLAG_REG_LOST]) |-> $past(flag_rd && !ol_s))
        else $error("regulation flag cleared without read");
    a_ident_read: assert property (
        rd_fire && rd_addr == `BBC_OFS_IDENT
        |=> rd_data_reg == {MAKER_ID, MAJOR_REV, MINOR_REV})
        else $error("identity byte wrong");
    a_unmapped_zero: assert property (
        rd_fire && (rd_addr == 8'h00 || rd_addr > `BBC_OFS_PRESET_B)
        |=> rd_data_reg == `BBC_RD_ZERO)
        else $error("unmapped read not zero");
    a_preset_msb: assert property (
        rd_fire && (rd_addr == `BBC_OFS_PRESET_A || rd_addr == `BBC_OFS_PRESET_B)
        |=> !rd_data_reg[7])
        else $error("preset bit 7 not zero");
    a_select_b: assert property (
        $rose(sel_s) |=> target_code_o == $past(pb_reg))
        else $error("select high did not pick preset B");
    a_discharge_on: assert property (
        !on_s || !setup_reg.enable |=> discharge_o && !converter_on_o)
        else $error("no discharge while off");
    a_ramp_dir: assert property (
        $changed(ramp_reg) |-> ($past(ramp_reg) < $past(target_reg))
            ? ramp_reg == $past(ramp_reg) + 7'h01
            : ramp_reg == $past(ramp_reg) - 7'h01)
        else $error("ramp stepped the wrong way");
    a_ramp_rate: assert property (
        $changed(ramp_reg) |-> $past(cnt_reg) == $past(step_len(setup_reg.slew)) - 10'h001)
        else $error("ramp step interval wrong");

    c_setup_write: cover property (wr_fire && wreq.addr == `BBC_OFS_SETUP);
    c_flag_clear: cover property ($fell(flags_reg[`BBC_FLAG_THERMAL]));
    c_ramp_done: cover property ($changed(ramp_reg) ##1 ramp_reg == target_reg);
    c_unmapped: cover property (rd_fire && rd_addr > `BBC_OFS_PRESET_B);

endmodule // bbc_regs

`default_nettype wire

// *** tb/bbc_master.sv ***
// Host model that drives the two-wire serial port as bus master
// Assumes the bench resolves SDA from sda_low, the device and a pull-up
`timescale 1ns/100ps
`default_nettype none
module bbc_master (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    // Idle bus with both lines released
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Start or repeated start: SDA falls while SCL is high
    task automatic start;
        sda_low = 1'b0;
        #400 scl = 1'b1;
        #400 sda_low = 1'b1;
        #400 scl = 1'b0;
    endtask
    // Stop: SDA rises while SCL is high
    task automatic stop;
        scl = 1'b0;
        #400 sda_low = 1'b1;
        #400 scl = 1'b1;
        #400 sda_low = 1'b0;
        #400;
    endtask
    // Eight bits MSB first plus the acknowledge bit; a one releases SDA
    task automatic bit9(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            #100 sda_low = !d[i];
            #300 scl = 1'b1;
            #300 q[i] = sda;
            #100 scl = 1'b0;
        end
        #100 sda_low = 1'b0;
    endtask
    // Register write: slave address, register, one data byte
    task automatic wr(input logic [7:0] a, input logic [7:0] r, input logic [7:0] d,
                      output logic ok);
        logic [8:0] q0, q1, q2;
        start();
        bit9({a, 1'b1}, q0);
        bit9({r, 1'b1}, q1);
        bit9({d, 1'b1}, q2);
        stop();
        ok = !(q0[0] | q1[0] | q2[0]);
    endtask
    // Register read with repeated start, closed by a NACK
    task automatic rd(input logic [7:0] r, output logic [7:0] d);
        logic [8:0] q;
        start();
        bit9({8'hea, 1'b1}, q);
        bit9({r, 1'b1}, q);
        start();
        bit9({8'heb, 1'b1}, q);
        bit9(9'h1ff, q);
        stop();
        d = q[8:1];
    endtask
endmodule // bbc_master
`default_nettype wire

// *** tb/test_buck_boost_config_regs.sv ***
// Self-checking bench for the buck-boost register bank
// Assumes bbc_pkg, bbc_regs and bbc_master are compiled first
`timescale 1ns/100ps
`default_nettype none
module test_buck_boost_config_regs;
    import bbc_pkg::*;
    logic mclk, link_clk, arst_n, ton, tsel, hot, bad, sda_oe, scl, m_low, con, dis, ok;
    bbc_setup_t setup;
    logic [6:0] tcode, vout;
    logic [7:0] d;
    int mismatches, num_checks;
    wire sda = !(sda_oe || m_low); // Pull-up wins when nobody drives
    bbc_regs bbc_regs_inst (.mclk(mclk), .arst_n(arst_n), .link_clk(link_clk), .scl_i(scl),
        .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .turn_on_pin(ton), .target_select_pin(tsel),
        .overtemp_i(hot), .out_of_reg_i(bad), .setup_o(setup), .vout_code_o(vout),
        .target_code_o(tcode), .converter_on_o(con), .discharge_o(dis));
    bbc_master bbc_master_inst (.scl(scl), .sda_low(m_low), .sda(sda));
    // Two unrelated clocks
    initial begin
        mclk = 1'b0;
        forever #20 mclk = !mclk;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #40 link_clk = !link_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Pins change at the falling edge, then settle through the synchronizers
    task automatic pins(input logic [3:0] v);
        @(negedge mclk) {ton, tsel, hot, bad} = v;
        repeat (8) @(negedge mclk);
    endtask
    task automatic t_reset;
        logic [7:0] exp [7] = '{8'h00, 8'h00, 8'h00, 8'ha4, 8'h3c, 8'h42, 8'h00};
        for (int r = 0; r < 7; r++) begin
            bbc_master_inst.rd(8'(r), d);
            chk(d, exp[r]);
        end
    endtask
    task automatic t_setup;
        bbc_master_inst.wr(8'hea, 8'h01, 8'hdf, ok);
        bbc_master_inst.rd(8'h01, d);
        chk(d, 8'hdf);
        pins(4'h8);
        chk(setup, 8'hdf);
        chk({6'h0, con, dis}, 8'h01);
        bbc_master_inst.wr(8'hea, 8'h01, 8'h23, ok);
        repeat (8) @(negedge mclk);
        chk({6'h0, con, dis}, 8'h02);
        pins(4'h0);
        chk({6'h0, con, dis}, 8'h01);
    endtask
    task automatic t_preset;
        bbc_master_inst.wr(8'hea, 8'h04, 8'hff, ok);
        bbc_master_inst.rd(8'h04, d);
        chk(d, 8'h7f);
        bbc_master_inst.wr(8'he8, 8'h04, 8'h11, ok);
        chk({7'h0, ok}, 8'h00);
        bbc_master_inst.wr(8'hea, 8'h03, 8'h00, ok);
        bbc_master_inst.rd(8'h03, d);
        chk(d, 8'ha4);
        chk({1'b0, tcode}, 8'h7f);
        pins(4'h4);
        chk({1'b0, tcode}, 8'h42);
        // Ramp settles on preset B, then climbs ten steps of 62 cycles
        repeat (4200) @(negedge mclk);
        chk({1'b0, vout}, 8'h42);
        pins(4'h0);
        repeat (642) @(negedge mclk);
        chk({1'b0, vout}, 8'h4c);
    endtask
    task automatic t_flags;
        pins(4'h3);
        bbc_master_inst.rd(8'h02, d);
        chk(d, 8'h03);
        pins(4'h0);
        bbc_master_inst.rd(8'h02, d);
        chk(d, 8'h03);
        bbc_master_inst.rd(8'h02, d);
        chk(d, 8'h00);
    endtask
    task automatic summarize;
        if (mismatches == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Main sequence after a 12 cycle reset and an initial STOP
    initial begin
        mismatches = 0;
        num_checks = 0;
        {ton, tsel, hot, bad} = 4'h0;
        arst_n = 1'b0;
        repeat (12) @(negedge mclk);
        arst_n = 1'b1;
        bbc_master_inst.stop();
        t_reset();
        t_setup();
        t_preset();
        t_flags();
        summarize();
    end
    // Watchdog well beyond the expected run of about 0.75 milliseconds
    initial begin
        #3000000;
        mismatches++;
        summarize();
    end
endmodule // test_buck_boost_config_regs
`default_nettype wire
